/* File: sfp_defines.svh */
// offsets, field positions, limits and timing counts of the sequencer
`ifndef SFP_DEFINES_SVH
`define SFP_DEFINES_SVH
// ****************************************
// register byte offsets
// ****************************************
`define SFP_OFS_CTRL   8'h00
`define SFP_OFS_PTR    8'h04
`define SFP_OFS_DATA   8'h08
`define SFP_OFS_STORE  8'h0C
`define SFP_OFS_STAT   8'h10
// ****************************************
// control register fields
// ****************************************
`define SFP_BIT_EN     0
`define SFP_BIT_ERS    1
`define SFP_BIT_WRT    2
`define SFP_BIT_REN    4
`define SFP_BIT_BUSY   6
// ****************************************
// command window and section limits
// ****************************************
`define SFP_WIN_CYCLES 3'h4
`define SFP_PAGE_BYTES 8'h80
`define SFP_N_RWS_END  14'h1C00
`define SFP_W_RWS_END  14'h3800
`define SFP_N_BOOT_3   14'h1F80
`define SFP_N_BOOT_2   14'h1F00
`define SFP_N_BOOT_1   14'h1E00
`define SFP_N_BOOT_0   14'h1C00
`define SFP_W_BOOT_3   14'h3F00
`define SFP_W_BOOT_2   14'h3E00
`define SFP_W_BOOT_1   14'h3C00
`define SFP_W_BOOT_0   14'h3800
`endif

/* File: sfp_pkg.sv */
// types shared by the self-programming sequencer
package sfp_pkg;
    typedef enum logic [1:0] {
        SFP_IDLE  = 2'b00,
        SFP_ARMED = 2'b01,
        SFP_BUSY  = 2'b10
    } sfp_state_t;
endpackage

/* File: sfp_section_map.sv */
// boot area start and readable-section decode for one address
`timescale 1ns/100ps
`include "sfp_defines.svh"
module sfp_section_map
    import sfp_pkg::*;
#(
    parameter bit WIDE = 1'b0
) (
    input  wire logic [1:0]  boot_size_select,
    input  wire logic [13:0] word_addr,
    output logic      [13:0] boot_start,
    output logic             in_readable
);
    logic [13:0] addr;

    // narrow part keeps a 13-bit counter, top bit ignored
    assign addr = WIDE ? word_addr : {1'b0, word_addr[12:0]};

    // boot start per size code and section limit
    always_comb begin
        if (WIDE) begin
            unique case (boot_size_select)
                2'b11: boot_start = `SFP_W_BOOT_3;
                2'b10: boot_start = `SFP_W_BOOT_2;
                2'b01: boot_start = `SFP_W_BOOT_1;
                2'b00: boot_start = `SFP_W_BOOT_0;
            endcase
            in_readable = addr < `SFP_W_RWS_END;
        end else begin
            unique case (boot_size_select)
                2'b11: boot_start = `SFP_N_BOOT_3;
                2'b10: boot_start = `SFP_N_BOOT_2;
                2'b01: boot_start = `SFP_N_BOOT_1;
                2'b00: boot_start = `SFP_N_BOOT_0;
            endcase
            in_readable = addr < `SFP_N_RWS_END;
        end
    end
endmodule

/* File: sfp_cmd_window.sv */
// counts the cycles in which a store may follow a command write
`timescale 1ns/100ps
`include "sfp_defines.svh"
module sfp_cmd_window
    import sfp_pkg::*;
(
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic arm,
    input  wire logic close,
    output logic      open
);
    logic [2:0] cnt;

    // reload on arm, clear on close, run down to zero otherwise
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 3'h0;
        end else if (arm) begin
            cnt <= `SFP_WIN_CYCLES;
        end else if (close) begin
            cnt <= 3'h0;
        end else if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
        end
    end

    assign open = cnt != 3'h0;
endmodule

/* File: sfp_boot_flash.sv */
// self-programming sequencer with ahb-lite register slave
`timescale 1ns/100ps
`include "sfp_defines.svh"
module sfp_boot_flash
    import sfp_pkg::*;
#(
    parameter bit WIDE = 1'b0
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        eeprom_write_busy,
    input  wire logic [1:0]  boot_size_select,
    input  wire logic [13:0] fetch_addr,
    input  wire logic        flash_done,
    output logic             fetch_allow,
    output logic      [13:0] boot_start,
    output logic             flash_erase,
    output logic             flash_write,
    output logic      [7:0]  flash_page,
    output logic             buf_load,
    output logic      [5:0]  buf_word,
    output logic      [15:0] buf_data
);
    sfp_state_t  state;
    logic        ap_valid;
    logic        ap_write;
    logic [7:0]  ap_addr;
    logic        cmd_en;
    logic        cmd_ers;
    logic        cmd_wrt;
    logic        cmd_ren;
    logic        readable_section_busy;
    logic [15:0] ptr;
    logic [15:0] data_word;
    logic        wr_ctrl;
    logic        wr_store;
    logic        cmd_ok;
    logic        store_hit;
    logic        store_go;
    logic        store_load;
    logic        win_open;
    logic        ptr_in_rws;
    logic        fetch_in_rws;
    logic [13:0] next_boot_start;
    logic [31:0] next_rdata;

    // ****************************************
    // ahb-lite slave
    // ****************************************

    // capture the address phase of each transfer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr  <= 8'h00;
        end else if (hready) begin
            ap_valid <= hsel & htrans[1];
            ap_write <= hwrite;
            ap_addr  <= haddr[7:0];
        end
    end

    // zero wait states, always okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    assign wr_ctrl  = ap_valid & ap_write & (ap_addr == `SFP_OFS_CTRL);
    assign wr_store = ap_valid & ap_write & (ap_addr == `SFP_OFS_STORE);

    // read mux, unmapped offsets read zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (haddr[7:0])
            `SFP_OFS_CTRL: begin
                next_rdata[`SFP_BIT_EN]   = cmd_en;
                next_rdata[`SFP_BIT_ERS]  = cmd_ers;
                next_rdata[`SFP_BIT_WRT]  = cmd_wrt;
                next_rdata[`SFP_BIT_REN]  = cmd_ren;
                next_rdata[`SFP_BIT_BUSY] = readable_section_busy;
            end
            `SFP_OFS_PTR:  next_rdata[15:0] = ptr;
            `SFP_OFS_DATA: next_rdata[15:0] = data_word;
            `SFP_OFS_STAT: begin
                next_rdata[0]   = eeprom_write_busy;
                next_rdata[2:1] = boot_size_select;
                next_rdata[3]   = state == SFP_BUSY;
            end
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // read data stands in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    // pointer and data word registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ptr       <= 16'h0000;
            data_word <= 16'h0000;
        end else if (ap_valid && ap_write) begin
            if (ap_addr == `SFP_OFS_PTR) begin
                ptr <= hwdata[15:0];
            end
            if (ap_addr == `SFP_OFS_DATA) begin
                data_word <= hwdata[15:0];
            end
        end
    end

    // ****************************************
    // command sequencer
    // ****************************************

    // a command is taken only when idle and eeprom is quiet
    assign cmd_ok = wr_ctrl && state == SFP_IDLE && !cmd_en
                    && !eeprom_write_busy
                    && hwdata[`SFP_BIT_EN];
    assign store_hit  = wr_store && state == SFP_ARMED && win_open;
    assign store_go   = store_hit && !ptr[0]
                        && (cmd_ers || cmd_wrt);
    assign store_load = store_hit && !ptr[0]
                        && !cmd_ers && !cmd_wrt && !cmd_ren;

    sfp_cmd_window u_window (
        .hclk    (hclk),
        .hresetn (hresetn),
        .arm     (cmd_ok),
        .close   (store_hit),
        .open    (win_open)
    );

    // command bits and sequencer state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state   <= SFP_IDLE;
            cmd_en  <= 1'b0;
            cmd_ers <= 1'b0;
            cmd_wrt <= 1'b0;
            cmd_ren <= 1'b0;
        end else begin
            unique case (state)
                SFP_IDLE: begin
                    if (cmd_ok) begin
                        state   <= SFP_ARMED;
                        cmd_en  <= 1'b1;
                        cmd_ers <= hwdata[`SFP_BIT_ERS];
                        cmd_wrt <= hwdata[`SFP_BIT_WRT];
                        cmd_ren <= hwdata[`SFP_BIT_REN];
                    end
                end
                SFP_ARMED: begin
                    if (store_go) begin
                        state <= SFP_BUSY;
                    end else if (store_hit || !win_open) begin
                        state   <= SFP_IDLE;
                        cmd_en  <= 1'b0;
                        cmd_ers <= 1'b0;
                        cmd_wrt <= 1'b0;
                        cmd_ren <= 1'b0;
                    end
                end
                SFP_BUSY: begin
                    if (flash_done) begin
                        state   <= SFP_IDLE;
                        cmd_en  <= 1'b0;
                        cmd_ers <= 1'b0;
                        cmd_wrt <= 1'b0;
                        cmd_ren <= 1'b0;
                    end
                end
                default: state <= SFP_IDLE;
            endcase
        end
    end

    // erase wins over write when both are requested
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flash_erase <= 1'b0;
            flash_write <= 1'b0;
            flash_page  <= 8'h00;
        end else begin
            flash_erase <= store_go && cmd_ers;
            flash_write <= store_go && !cmd_ers;
            if (store_go) begin
                flash_page <= ptr[14:7];
            end
        end
    end

    // page buffer fill, word bits of the pointer pick the slot
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            buf_load <= 1'b0;
            buf_word <= 6'h00;
            buf_data <= 16'h0000;
        end else begin
            buf_load <= store_load;
            if (store_load) begin
                buf_word <= ptr[6:1];
                buf_data <= data_word;
            end
        end
    end

    // busy flag, a new set wins over a clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            readable_section_busy <= 1'b0;
        end else if (store_go && ptr_in_rws) begin
            readable_section_busy <= 1'b1;
        end else if (store_load
                     || (store_hit && !ptr[0] && cmd_ren)) begin
            readable_section_busy <= 1'b0;
        end
    end

    // ****************************************
    // section decode and fetch gating
    // ****************************************

    sfp_section_map #(.WIDE(WIDE)) u_ptr_map (
        .boot_size_select (boot_size_select),
        .word_addr        (ptr[14:1]),
        .boot_start       (next_boot_start),
        .in_readable      (ptr_in_rws)
    );

    sfp_section_map #(.WIDE(WIDE)) u_fetch_map (
        .boot_size_select (boot_size_select),
        .word_addr        (fetch_addr),
        .boot_start       (),
        .in_readable      (fetch_in_rws)
    );

    // block readable-section fetches while programming
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fetch_allow <= 1'b0;
            boot_start  <= 14'h0000;
        end else begin
            fetch_allow <= !(fetch_in_rws && (state == SFP_BUSY
                             || readable_section_busy));
            boot_start  <= next_boot_start;
        end
    end

    // ****************************************
    // checks
    // ****************************************

    chk_window_expiry: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (state == SFP_ARMED && !win_open)
        |=> (state == SFP_IDLE && !cmd_en))
        else $error("command survived its store window");

    chk_window_length: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (cmd_ok ##1 (!wr_store) [*4])
        |=> ##1 (state == SFP_IDLE && !cmd_en))
        else $error("store window not four cycles");

    chk_done_clears: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (state == SFP_BUSY && flash_done) |=> !cmd_en)
        else $error("enable stayed set after completion");

    chk_page_index: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (flash_erase || flash_write)
        |-> flash_page == $past(ptr[14:7]))
        else $error("page index not from pointer");

    chk_odd_pointer: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (store_hit && ptr[0])
        |=> !(flash_erase || flash_write || buf_load))
        else $error("store with pointer bit 0 acted");

    chk_fetch_block: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (state == SFP_BUSY && fetch_in_rws) |=> !fetch_allow)
        else $error("readable section fetched while busy");

    chk_busy_set: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (store_go && ptr_in_rws)
        |=> readable_section_busy && (flash_erase || flash_write))
        else $error("busy flag not set by section operation");

    chk_load_clear: assert property (
        @(posedge hclk) disable iff (!hresetn)
        buf_load |-> !readable_section_busy
                     && buf_word == $past(ptr[6:1]))
        else $error("page load did not clear busy");

    chk_boot_table: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (boot_size_select == 2'b00)
        |=> boot_start == (WIDE ? 14'h3800 : 14'h1C00))
        else $error("boot start wrong for largest area");
endmodule

/* File: sfp_flash_model.sv */
// flash macro model: answers an erase or write start after a busy time
`timescale 1ns/100ps
module sfp_flash_model (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic slow,
    input  wire logic flash_erase,
    input  wire logic flash_write,
    output logic      flash_done
);
    int cnt;
    // ********
    // busy countdown, then one done pulse; done stays low between ops
    // ********
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 0;
            flash_done <= 1'b0;
        end else begin
            flash_done <= (cnt == 1);
            if (flash_erase || flash_write)
                cnt <= slow ? 40 : 3;
            else if (cnt != 0)
                cnt <= cnt - 1;
        end
    end
endmodule

/* File: boot_flash_self_program_test.sv */
// self-checking bench of the self-programming sequencer, both variants
`timescale 1ns/100ps
`include "sfp_defines.svh"
module boot_flash_self_program_test import sfp_pkg::*;;
    logic        hclk = 1'b0;
    logic        hresetn, hsel, hwrite, hready, slow, eeprom_write_busy;
    logic        flash_done, fetch_allow, fetch_allow_w, hreadyout, hresp;
    logic        flash_erase, flash_write, buf_load;
    logic        flash_erase_w, flash_write_w;
    logic [1:0]  htrans, boot_size_select;
    logic [2:0]  hsize;
    logic [5:0]  buf_word;
    logic [7:0]  flash_page, flash_page_w, page;
    logic [13:0] fetch_addr, boot_start, boot_start_w;
    logic [15:0] buf_data, ptr;
    logic [31:0] haddr, hwdata, hrdata, rd, d, op_exp;
    int          err_count = 0;
    int          n_tests = 0;
    int          cyc = 0;
    logic [31:0] exp_ops[$], exp_loads[$];
    logic [13:0] tab_n[4] = '{14'h1C00, 14'h1E00, 14'h1F00, 14'h1F80};
    logic [13:0] tab_w[4] = '{14'h3800, 14'h3C00, 14'h3E00, 14'h3F00};

    assign hready = hreadyout;
    always #4 hclk = ~hclk;

    sfp_boot_flash #(.WIDE(1'b0)) dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .eeprom_write_busy(eeprom_write_busy),
        .boot_size_select(boot_size_select), .fetch_addr(fetch_addr),
        .flash_done(flash_done), .fetch_allow(fetch_allow),
        .boot_start(boot_start), .flash_erase(flash_erase),
        .flash_write(flash_write), .flash_page(flash_page),
        .buf_load(buf_load), .buf_word(buf_word), .buf_data(buf_data));
    sfp_boot_flash #(.WIDE(1'b1)) dut_w (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(), .hreadyout(), .hresp(),
        .eeprom_write_busy(eeprom_write_busy),
        .boot_size_select(boot_size_select), .fetch_addr(fetch_addr),
        .flash_done(flash_done), .fetch_allow(fetch_allow_w),
        .boot_start(boot_start_w), .flash_erase(flash_erase_w),
        .flash_write(flash_write_w), .flash_page(flash_page_w),
        .buf_load(), .buf_word(), .buf_data());
    sfp_flash_model fm_u (.hclk(hclk), .hresetn(hresetn), .slow(slow),
        .flash_erase(flash_erase), .flash_write(flash_write),
        .flash_done(flash_done));

    // ********
    // compare, verdict and bus tasks
    // ********
    task automatic check(string nm, logic [31:0] seen, logic [31:0] ex);
        n_tests++;
        if (seen !== ex) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, ex, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // one single transfer: address phase, then data phase
    task automatic bus(logic wr, logic [7:0] a, logic [31:0] wd);
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    // pointer, command word, then the store inside the window
    // no interrupts are modelled, so the timed pair is never split
    task automatic cmd(logic [15:0] p, logic [7:0] c);
        bus(1'b1, `SFP_OFS_PTR, {16'h0000, p});
        bus(1'b1, `SFP_OFS_CTRL, {24'h000000, c});
        bus(1'b1, `SFP_OFS_STORE, 32'h00000000);
    endtask
    task automatic wait_idle();
        rd = 32'h00000001;
        while (rd[0] !== 1'b0) bus(1'b0, `SFP_OFS_CTRL, 32'h00000000);
    endtask
    task automatic fetch(logic [13:0] a, logic en, logic ew);
        fetch_addr <= a;
        repeat (2) @(posedge hclk);
        check("fetch_allow", fetch_allow, en);
        check("fetch_allow_w", fetch_allow_w, ew);
    endtask

    // hang guard
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            stop_test();
        end
    end
    // flash starts and buffer loads against the expected queues
    always @(posedge hclk) begin
        if (flash_erase || flash_write) begin
            op_exp = exp_ops.size() ? exp_ops.pop_front() : 32'hFFFFFFFF;
            check("op_page", {flash_write, flash_erase, flash_page},
                op_exp);
            check("op_page_w", {flash_write_w, flash_erase_w, flash_page_w},
                op_exp);
        end
        if (buf_load)
            check("load", {buf_word, buf_data},
                exp_loads.size() ? exp_loads.pop_front() : 32'hFFFFFFFF);
    end

    // ********
    // main sequence
    // ********
    initial begin
        hresetn = 1'b0;
        hsel = 1'b1;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        eeprom_write_busy = 1'b0;
        boot_size_select = 2'h0;
        fetch_addr = 14'h0000;
        slow = 1'b0;
        void'($urandom(60732));
        repeat (8) @(posedge hclk);
        check("reset_rdata", hrdata, 32'h00000000);
        check("reset_ready", {hreadyout, hresp}, 2'h2);
        check("reset_out", {fetch_allow, boot_start}, 15'h0000);
        hresetn <= 1'b1;
        // boot area start per size code, status readback
        for (int i = 0; i < 4; i++) begin
            boot_size_select <= i[1:0];
            eeprom_write_busy <= i[0];
            repeat (2) @(posedge hclk);
            check("boot_start", boot_start, tab_n[i]);
            check("boot_start_w", boot_start_w, tab_w[i]);
            bus(1'b0, `SFP_OFS_STAT, 32'h00000000);
            check("status", rd, {i[1:0], i[0]});
        end
        eeprom_write_busy <= 1'b0;
        // erase a readable page; busy cleared by loads, then re-enable
        for (int k = 0; k < 2; k++) begin
            page = 8'($urandom_range(111));
            slow <= (k == 0);
            exp_ops.push_back({2'b01, page});
            cmd({1'b0, page, 7'h00}, 8'h03);
            bus(1'b0, `SFP_OFS_CTRL, 32'h00000000);
            check("busy_set", rd[6], 1'b1);
            if (k == 0) check("enable", rd[0], 1'b1);
            fetch(14'h1C00, 1'b1, 1'b0);
            fetch(14'h3800, 1'b0, 1'b1);
            wait_idle();
            if (k == 0) begin
                // fill the whole page, pointer up by two per word
                for (int b = 0; b < `SFP_PAGE_BYTES; b += 2) begin
                    ptr = {1'b0, page, 7'h00} | 16'(b);
                    d = $urandom;
                    exp_loads.push_back({ptr[6:1], d[15:0]});
                    bus(1'b1, `SFP_OFS_DATA, d);
                    cmd(ptr, 8'h01);
                    wait_idle();
                end
            end else
                cmd(16'h0000, 8'h11);
            bus(1'b0, `SFP_OFS_CTRL, 32'h00000000);
            check("busy_clr", rd[6], 1'b0);
            fetch(14'h0000, 1'b1, 1'b1);
        end
        // narrow-variant locked-section write and erase+write both leave busy clear (these pages are readable in the wide one)
        for (int k = 0; k < 2; k++) begin
            page = 8'($urandom_range(127, 112));
            exp_ops.push_back({2'b01 << (1 - k), page});
            cmd({1'b0, page, 7'h00}, k ? 8'h07 : 8'h05);
            bus(1'b0, `SFP_OFS_CTRL, 32'h00000000);
            check("busy_nrw", rd[6], 1'b0);
            wait_idle();
        end
        // refused commands: late store, odd pointer, eeprom busy
        bus(1'b1, `SFP_OFS_CTRL, 32'h00000003);
        repeat (6) @(posedge hclk);
        bus(1'b1, `SFP_OFS_STORE, 32'h00000000);
        bus(1'b0, `SFP_OFS_CTRL, 32'h00000000);
        check("late", rd[2:0], 3'h0);
        cmd(16'h0001, 8'h03);
        repeat (6) @(posedge hclk);
        bus(1'b0, `SFP_OFS_CTRL, 32'h00000000);
        check("odd_ptr", rd[2:0], 3'h0);
        eeprom_write_busy <= 1'b1;
        cmd(16'h0000, 8'h03);
        bus(1'b0, `SFP_OFS_CTRL, 32'h00000000);
        check("ee_busy", rd[2:0], 3'h0);
        eeprom_write_busy <= 1'b0;
        // unmapped place reads zero even after a write
        bus(1'b1, 8'h20, $urandom);
        bus(1'b0, 8'h20, 32'h00000000);
        check("unmapped", rd, 32'h00000000);
        check("okay", {hreadyout, hresp}, 2'h2);
        repeat (4) @(posedge hclk);
        check("pending", exp_ops.size() + exp_loads.size(), 0);
        stop_test();
    end
endmodule
